// *** core/pic_pkg.sv ***
package pic_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REQ_OFS  = 8'h00;  // Pending request bits
  localparam logic [7:0] ENA_OFS  = 8'h04;  // Per-slot enable bits
  localparam logic [7:0] EDGE_OFS = 8'h08;  // Active edge per pin, 1 = rising
  localparam logic [7:0] SEL_OFS  = 8'h0c;  // Shared-slot and channel selects
  localparam logic [7:0] FLAG_OFS = 8'h10;  // Global disable flag in bit 0
  localparam logic [7:0] STAT_OFS = 8'h14;  // Read-only engine status

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SEL_SLOT8_TMR  = 0;  // 1: second 8-bit timer drives slot 8
  localparam int SEL_SLOT9_TMR  = 1;  // 1: third 8-bit timer drives slot 9
  localparam int SEL_SLOT13_TMR = 2;  // 1: first 8-bit timer drives slot 13
  localparam int SEL_SLOT16_PIN = 3;  // 1: trigger pin drives slot 16
  localparam int SEL_EXT_TRIG   = 4;  // 1: converter uses external trigger
  localparam int SEL_SER1       = 5;  // 1: serial channel 1 selected
  localparam int SEL_SER2       = 6;  // 1: serial channel 2 selected
  localparam int STAT_BUSY      = 8;  // Engine not idle

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [14:0] REQ_RST  = 15'h0000;
  localparam logic [14:0] ENA_RST  = 15'h0000;
  localparam logic [6:0]  EDGE_RST = 7'h00;
  localparam logic [6:0]  SEL_RST  = 7'h00;
  localparam logic        FLAG_RST = 1'b1;

  // ---------------------------------------------------------------------------
  // Priorities and vectors
  // ---------------------------------------------------------------------------
  localparam int          NUM_SLOTS   = 15;        // Maskable slots, priority 2..16
  localparam int          NUM_PINS    = 8;         // Seven edge pins plus trigger pin
  localparam logic [4:0]  PRIO_RESET  = 5'h01;
  localparam logic [4:0]  PRIO_FIRST  = 5'h02;     // Priority of slot 0
  localparam logic [4:0]  PRIO_TRAP   = 5'h11;
  localparam logic [15:0] VEC_TOP     = 16'hfffc;  // Low byte of the reset vector
  localparam logic [15:0] VEC_RST_HI  = 16'hfffd;

endpackage : pic_pkg

// *** core/pic_ctrl.sv ***
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Twenty sources: eight pins, eleven internal, trap
// - Maskable taken when request, enable set, flag clear
// - Software sets and clears every enable bit
// - Software clears requests; writing 1 never sets
// - Trap and reset ignore enables and flag
// - Simultaneous requests: highest priority granted first
// - Acceptance halts core, pushes PC and status
// - Vector fetched into PC during the push
// - Acceptance sets flag, clears granted request bit
// - Reset is priority 1, vector FFFD/FFFC
// - Pin edges, selectable polarity; first pin priority 2
// - Serial 1 receive priority 4, transmit 5
// - General timers underflow at priorities 6, 7
// - Slot 8 shared pin d / timer two
// - Slot 9 shared pin e / timer three
// - Counter pins request at priorities 10, 11
// - Serial 2 completion requests at priority 12
// - Slot 13 shared pin c / timer one
// - Output-port timers underflow at priorities 14, 15
// - Slot 16 converter done or trigger fall
// - Trap is non-maskable, priority 17, FFDD/FFDC
module pic_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External pins, asynchronous
  input  wire logic        ext_edge_irq_a,
  input  wire logic        ext_edge_irq_b,
  input  wire logic        ext_edge_irq_c,
  input  wire logic        ext_edge_irq_d,
  input  wire logic        ext_edge_irq_e,
  input  wire logic        counter_pin_a,
  input  wire logic        counter_pin_b,
  input  wire logic        converter_trigger_pin,
  // Peripheral event pulses, same clock
  input  wire logic        ser1_rx_done,
  input  wire logic        ser1_tx_done,
  input  wire logic        ser2_done,
  input  wire logic        tmr_x_uflow,
  input  wire logic        tmr_y_uflow,
  input  wire logic        tmr1_uflow,
  input  wire logic        tmr2_uflow,
  input  wire logic        tmr3_uflow,
  input  wire logic        tmr_a_uflow,
  input  wire logic        tmr_b_uflow,
  input  wire logic        adc_done,
  // Processor core
  input  wire logic        software_trap_instruction,
  input  wire logic        irq_ack,
  output logic             irq_offer,
  output logic [4:0]       irq_prio,
  output logic             core_halt,
  output logic             stack_push,
  output logic [1:0]       push_sel,
  output logic             vec_fetch,
  output logic [15:0]      vec_addr
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Lowest set index wins, so slot 0 (priority 2) beats all others
  function automatic logic [3:0] pick_slot(input logic [14:0] pend);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = pic_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pick_slot

  // Each priority step moves the vector pair down by two bytes
  function automatic logic [15:0] vec_lo(input logic [4:0] prio);
    logic [4:0] step;
    step = prio - pic_pkg::PRIO_RESET;
    return pic_pkg::VEC_TOP - {10'h000, step, 1'b0};
  endfunction : vec_lo

  typedef enum {
    ST_RST_LO, ST_RST_HI, ST_IDLE, ST_OFFER, ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PS
  } pic_state_e;

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------------
  logic [7:0] pin_raw;   // Pins gathered into one vector
  logic [7:0] pin_s1;    // First stage, read only by the second
  logic [7:0] pin_s2;    // Safe to use
  logic [7:0] pin_s3;    // Previous value for edge detection
  logic [7:0] edge_hit;  // One-cycle pulse on the active edge
  logic [6:0] edge_pol;  // 1 = rising, per edge pin

  assign pin_raw = {converter_trigger_pin, counter_pin_b, counter_pin_a, ext_edge_irq_e,
                    ext_edge_irq_d, ext_edge_irq_c, ext_edge_irq_b, ext_edge_irq_a};

  // Sync chain registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Edge select per pin; the trigger pin only counts falling edges
  generate
    for (genvar g = 0; g < pic_pkg::NUM_PINS; g++) begin : g_edge
      if (g < 7) begin : g_sel
        assign edge_hit[g] = edge_pol[g] ? (pin_s2[g] & ~pin_s3[g])
                                         : (~pin_s2[g] & pin_s3[g]);
      end else begin : g_fall
        assign edge_hit[g] = ~pin_s2[g] & pin_s3[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Source to slot mapping
  // ---------------------------------------------------------------------------
  logic [6:0]  src_sel;  // Shared-slot and channel selection
  logic [14:0] set_ev;   // Hardware events per slot this cycle

  // Only the chosen source of a shared slot reaches its request bit
  always_comb begin
    set_ev[0]  = edge_hit[0];
    set_ev[1]  = edge_hit[1];
    set_ev[2]  = src_sel[pic_pkg::SEL_SER1] & ser1_rx_done;
    set_ev[3]  = src_sel[pic_pkg::SEL_SER1] & ser1_tx_done;
    set_ev[4]  = tmr_x_uflow;
    set_ev[5]  = tmr_y_uflow;
    set_ev[6]  = src_sel[pic_pkg::SEL_SLOT8_TMR] ? tmr2_uflow : edge_hit[3];
    set_ev[7]  = src_sel[pic_pkg::SEL_SLOT9_TMR] ? tmr3_uflow : edge_hit[4];
    set_ev[8]  = edge_hit[5];
    set_ev[9]  = edge_hit[6];
    set_ev[10] = src_sel[pic_pkg::SEL_SER2] & ser2_done;
    set_ev[11] = src_sel[pic_pkg::SEL_SLOT13_TMR] ? tmr1_uflow : edge_hit[2];
    set_ev[12] = tmr_a_uflow;
    set_ev[13] = tmr_b_uflow;
    // Pin counts only with external triggering chosen as well
    set_ev[14] = src_sel[pic_pkg::SEL_SLOT16_PIN]
               ? (src_sel[pic_pkg::SEL_EXT_TRIG] & edge_hit[7]) : adc_done;
  end

  // ---------------------------------------------------------------------------
  // Register file and APB slave
  // ---------------------------------------------------------------------------
  logic [14:0] req, next_req;        // Pending requests
  logic [14:0] ena, next_ena;        // Enables
  logic [6:0]  next_edge_pol;
  logic [6:0]  next_src_sel;
  logic        dis_flag, next_dis_flag;  // Global disable flag
  logic        trap_pend, next_trap_pend;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_take;              // Write completes this edge
  logic        acc_phase;            // Access phase, answer not yet given
  logic        addr_ok;
  logic [14:0] grant_mask;           // Slot accepted this cycle
  logic        trap_taken;
  logic        flag_set;
  logic [4:0]  last_prio;
  pic_state_e  state, next_state;

  // One wait state: pready rises in the second access cycle
  assign acc_phase = psel & penable & ~pready;
  assign wr_take   = psel & penable & pready & pwrite & ~pslverr;
  assign addr_ok   = (paddr == pic_pkg::REQ_OFS) || (paddr == pic_pkg::ENA_OFS)
                  || (paddr == pic_pkg::EDGE_OFS) || (paddr == pic_pkg::SEL_OFS)
                  || (paddr == pic_pkg::FLAG_OFS) || (paddr == pic_pkg::STAT_OFS);

  // Register next values; hardware sets win over software clears
  always_comb begin
    next_req       = req;
    next_ena       = ena;
    next_edge_pol  = edge_pol;
    next_src_sel   = src_sel;
    next_dis_flag  = dis_flag;
    next_trap_pend = trap_pend;
    if (wr_take) begin
      unique case (paddr)
        pic_pkg::REQ_OFS:  next_req      = req & pwdata[14:0];
        pic_pkg::ENA_OFS:  next_ena      = pwdata[14:0];
        pic_pkg::EDGE_OFS: next_edge_pol = pwdata[6:0];
        pic_pkg::SEL_OFS:  next_src_sel  = pwdata[6:0];
        pic_pkg::FLAG_OFS: next_dis_flag = pwdata[0];
        default: ;
      endcase
    end
    next_req = (next_req & ~grant_mask) | set_ev;
    if (flag_set) begin
      next_dis_flag = 1'b1;
    end
    if (trap_taken) begin
      next_trap_pend = 1'b0;
    end
    if (software_trap_instruction) begin
      next_trap_pend = 1'b1;
    end
  end

  // Read mux and answer; unmapped addresses answer with pslverr
  always_comb begin
    next_pready  = acc_phase;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (acc_phase) begin
      next_pslverr = ~addr_ok;
      next_prdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          pic_pkg::REQ_OFS:  next_prdata = {17'h00000, req};
          pic_pkg::ENA_OFS:  next_prdata = {17'h00000, ena};
          pic_pkg::EDGE_OFS: next_prdata = {25'h0000000, edge_pol};
          pic_pkg::SEL_OFS:  next_prdata = {25'h0000000, src_sel};
          pic_pkg::FLAG_OFS: next_prdata = {31'h00000000, dis_flag};
          pic_pkg::STAT_OFS: next_prdata = {23'h000000, (state != ST_IDLE), 3'h0, last_prio};
          default:           next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register file and bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req       <= pic_pkg::REQ_RST;
      ena       <= pic_pkg::ENA_RST;
      edge_pol  <= pic_pkg::EDGE_RST;
      src_sel   <= pic_pkg::SEL_RST;
      dis_flag  <= pic_pkg::FLAG_RST;
      trap_pend <= 1'b0;
      pready    <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
    end else begin
      req       <= next_req;
      ena       <= next_ena;
      edge_pol  <= next_edge_pol;
      src_sel   <= next_src_sel;
      dis_flag  <= next_dis_flag;
      trap_pend <= next_trap_pend;
      pready    <= next_pready;
      prdata    <= next_prdata;
      pslverr   <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------------------
  // Arbitration and acceptance sequence
  // ---------------------------------------------------------------------------
  logic [14:0] pend;       // Maskable slots that may be taken
  logic [3:0]  win_slot;
  logic        next_irq_offer;
  logic [4:0]  next_irq_prio;
  logic        next_core_halt;
  logic        next_stack_push;
  logic [1:0]  next_push_sel;
  logic        next_vec_fetch;
  logic [15:0] next_vec_addr;
  logic [4:0]  next_last_prio;

  assign pend     = req & ena & {15{~dis_flag}};
  assign win_slot = pick_slot(pend);

  // The choice is frozen once offered, so the core sees a stable vector
  always_comb begin
    next_state      = state;
    next_irq_prio   = irq_prio;
    next_last_prio  = last_prio;
    grant_mask      = 15'h0000;
    trap_taken      = 1'b0;
    flag_set        = 1'b0;
    unique case (state)
      ST_RST_LO: next_state = ST_RST_HI;
      ST_RST_HI: next_state = ST_IDLE;
      ST_IDLE: begin
        if (|pend) begin
          next_irq_prio = pic_pkg::PRIO_FIRST + {1'b0, win_slot};
          next_state    = ST_OFFER;
        end else if (trap_pend) begin
          next_irq_prio = pic_pkg::PRIO_TRAP;
          next_state    = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (irq_ack) begin
          flag_set       = 1'b1;
          next_last_prio = irq_prio;
          next_state     = ST_PUSH_PCH;
          if (irq_prio == pic_pkg::PRIO_TRAP) begin
            trap_taken = 1'b1;
          end else begin
            grant_mask = 15'(15'h0001 << (irq_prio - pic_pkg::PRIO_FIRST));
          end
        end
      end
      ST_PUSH_PCH: next_state = ST_PUSH_PCL;
      ST_PUSH_PCL: next_state = ST_PUSH_PS;
      ST_PUSH_PS:  next_state = ST_IDLE;
    endcase
  end

  // Outputs follow the next state, so they line up with the state register
  always_comb begin
    next_irq_offer  = (next_state == ST_OFFER);
    next_core_halt  = (next_state == ST_PUSH_PCH) || (next_state == ST_PUSH_PCL)
                   || (next_state == ST_PUSH_PS);
    next_stack_push = next_core_halt;
    next_push_sel   = 2'h0;
    next_vec_fetch  = 1'b0;
    next_vec_addr   = vec_addr;
    unique case (next_state)
      ST_RST_LO: begin
        next_vec_fetch = 1'b1;
        next_vec_addr  = pic_pkg::VEC_TOP;
      end
      ST_RST_HI: begin
        next_vec_fetch = 1'b1;
        next_vec_addr  = pic_pkg::VEC_RST_HI;
      end
      ST_PUSH_PCH: begin
        next_push_sel  = 2'h0;
        next_vec_fetch = 1'b1;
        next_vec_addr  = vec_lo(next_irq_prio);
      end
      ST_PUSH_PCL: begin
        next_push_sel  = 2'h1;
        next_vec_fetch = 1'b1;
        next_vec_addr  = vec_lo(next_irq_prio) + 16'h0001;
      end
      ST_PUSH_PS:  next_push_sel = 2'h2;
      default: ;
    endcase
  end

  // Engine registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_RST_LO;
      irq_prio   <= pic_pkg::PRIO_RESET;
      last_prio  <= pic_pkg::PRIO_RESET;
      irq_offer  <= 1'b0;
      core_halt  <= 1'b0;
      stack_push <= 1'b0;
      push_sel   <= 2'h0;
      vec_fetch  <= 1'b1;
      vec_addr   <= pic_pkg::VEC_TOP;
    end else begin
      state      <= next_state;
      irq_prio   <= next_irq_prio;
      last_prio  <= next_last_prio;
      irq_offer  <= next_irq_offer;
      core_halt  <= next_core_halt;
      stack_push <= next_stack_push;
      push_sel   <= next_push_sel;
      vec_fetch  <= next_vec_fetch;
      vec_addr   <= next_vec_addr;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_req_no_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == pic_pkg::REQ_OFS && set_ev == 15'h0000)
      |=> ((req & ~$past(req)) == 15'h0000))
    else $error("Software write set a request bit");

  a_ena_write_back: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_take && paddr == pic_pkg::ENA_OFS) |=> (ena == $past(pwdata[14:0])))
    else $error("Enable write not stored");

  a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(irq_offer) && irq_prio != pic_pkg::PRIO_TRAP)
      |-> ($past(dis_flag) == 1'b0) && (($past(req) & $past(ena)) != 15'h0000))
    else $error("Masked source offered");

  a_trap_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && trap_pend && pend == 15'h0000)
      |=> irq_offer && irq_prio == pic_pkg::PRIO_TRAP)
    else $error("Trap not offered");

  a_top_prio_first: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && pend[0]) |=> irq_offer && irq_prio == 5'h02)
    else $error("Highest priority slot not chosen");

  a_accept_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_OFFER && irq_ack && (grant_mask & set_ev) == 15'h0000)
      |=> dis_flag && ((req & $past(grant_mask)) == 15'h0000))
    else $error("Acceptance did not set flag or clear request");

  a_push_three: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_OFFER && irq_ack)
      |=> (core_halt && stack_push) [*3] ##1 !stack_push)
    else $error("Context push not three cycles");

  a_vector_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_OFFER && irq_ack)
      |=> vec_fetch && stack_push && vec_addr == vec_lo($past(irq_prio))
          ##1 vec_fetch && vec_addr == vec_lo($past(irq_prio, 2)) + 16'h0001)
    else $error("Vector fetch wrong");

  a_reset_vector: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_RST_HI) |-> vec_addr == pic_pkg::VEC_RST_HI && $past(vec_addr) == pic_pkg::VEC_TOP)
    else $error("Reset vector wrong");

  a_event_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    (set_ev != 15'h0000) |=> ((req & $past(set_ev)) == $past(set_ev)))
    else $error("Source event lost");

  a_slot8_timer: assert property (@(posedge pclk) disable iff (!presetn)
    (src_sel[pic_pkg::SEL_SLOT8_TMR] && !tmr2_uflow && !(wr_take && paddr == pic_pkg::REQ_OFS)
      && !req[6] && grant_mask == 15'h0000) |=> !req[6])
    else $error("Unselected pin drove slot 8");

endmodule : pic_ctrl

// *** verification/pic_core_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Processor core: takes an offered interrupt after a chosen latency
// ---------------------------------------------------------------------------
module pic_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_offer,  // Offer from the controller
  input  wire logic [3:0] ack_delay,  // Cycles of offer, beyond the first, before the answer
  output logic            irq_ack     // One-cycle acceptance
);
  logic [3:0] wait_cnt;  // Cycles the current offer has stood

  // A slow core lets the offer stand, so a frozen choice gets exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_ack || !irq_offer) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == ack_delay) begin
      irq_ack  <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : pic_core_model

// *** verification/prioritized_interrupt_controller_bench.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Self-checking bench: registers, sources, priority and acceptance
// ---------------------------------------------------------------------------
module prioritized_interrupt_controller_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, trap;
  logic [7:0]  paddr, pins;      // Pins a,b,c,d,e, counters a,b, trigger
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] ev;               // Peripheral event pulses
  logic        irq_ack, irq_offer, core_halt, stack_push, vec_fetch;
  logic [4:0]  irq_prio;
  logic [1:0]  push_sel;
  logic [15:0] vec_addr;
  logic [3:0]  ack_delay;        // Core answer latency
  int          mismatches, comparisons;
  int          es[11] = '{2, 3, 10, 4, 5, 11, 6, 7, 12, 13, 14};  // Slot per event
  int          ps[8]  = '{0, 1, 11, 6, 7, 8, 9, 14};              // Slot per pin

  pic_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_edge_irq_a(pins[0]), .ext_edge_irq_b(pins[1]), .ext_edge_irq_c(pins[2]), .ext_edge_irq_d(pins[3]),
    .ext_edge_irq_e(pins[4]), .counter_pin_a(pins[5]), .counter_pin_b(pins[6]), .converter_trigger_pin(pins[7]),
    .ser1_rx_done(ev[0]), .ser1_tx_done(ev[1]), .ser2_done(ev[2]), .tmr_x_uflow(ev[3]), .tmr_y_uflow(ev[4]),
    .tmr1_uflow(ev[5]), .tmr2_uflow(ev[6]), .tmr3_uflow(ev[7]), .tmr_a_uflow(ev[8]), .tmr_b_uflow(ev[9]),
    .adc_done(ev[10]), .software_trap_instruction(trap), .irq_ack(irq_ack), .irq_offer(irq_offer),
    .irq_prio(irq_prio), .core_halt(core_halt), .stack_push(stack_push), .push_sel(push_sel),
    .vec_fetch(vec_fetch), .vec_addr(vec_addr));
  pic_core_model CORE (.pclk(pclk), .presetn(presetn), .irq_offer(irq_offer), .ack_delay(ack_delay),
    .irq_ack(irq_ack));

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits for an offer, then follows the three push cycles
  task automatic take(input logic [4:0] prio);
    logic [15:0] lo;
    int n;
    lo = 16'hfffc - 16'(2 * (prio - 5'h01));
    n = 0;
    while (core_halt !== 1'b1 && n < 40) begin
      if (irq_offer === 1'b1) chk("irq_prio", 32'(prio), 32'(irq_prio));
      @(posedge pclk);
      n++;
    end
    if (core_halt !== 1'b1) begin
      mismatches++;
      summarize();
    end
    for (int k = 0; k < 3; k++) begin
      chk("push_step", 32'({2'b11, 2'(k), k < 2, lo + 16'(k != 0)}),
          32'({core_halt, stack_push, push_sel, vec_fetch, vec_addr}));
      @(posedge pclk);
    end
    chk("halt_end", 32'h0, 32'(core_halt));
  endtask : take

  task automatic t_regs();
    apb(1'b1, pic_pkg::ENA_OFS, 32'hffff_ffff);
    apb(1'b0, pic_pkg::ENA_OFS, 32'h0);
    chk("ena_set", 32'h7fff, rd);
    apb(1'b1, pic_pkg::ENA_OFS, 32'h0);
    apb(1'b0, pic_pkg::ENA_OFS, 32'h0);
    chk("ena_clear", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
  endtask : t_regs

  // Each pin toggled and restored: rising first for the edge pins, falling first for the trigger
  task automatic t_pins();
    apb(1'b1, pic_pkg::SEL_OFS, 32'h18);
    apb(1'b1, pic_pkg::EDGE_OFS, 32'h7f);
    for (int i = 0; i < 8; i++) begin
      pins[i] <= ~pins[i];
      repeat (5) @(posedge pclk);
      apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
      chk("pin_req", 32'h1 << ps[i], rd);
      apb(1'b1, pic_pkg::REQ_OFS, 32'h0);
      pins[i] <= ~pins[i];
      repeat (5) @(posedge pclk);
      apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
      chk("pin_quiet", 32'h0, rd);
    end
  endtask : t_pins

  task automatic t_events();
    apb(1'b1, pic_pkg::SEL_OFS, 32'h67);
    // Pin d edge while its shared slot belongs to the timer must not count
    pins[3] <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
    chk("unsel_pin", 32'h0, rd);
    for (int i = 0; i < 11; i++) begin
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      apb(1'b1, pic_pkg::REQ_OFS, 32'h7fff);
      apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
      chk("event_req", 32'h1 << es[i], rd);
      apb(1'b1, pic_pkg::REQ_OFS, 32'h0);
    end
    apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
    chk("req_clear", 32'h0, rd);
  endtask : t_events

  // Masked pair, then priority order, trap while disabled, slow core
  task automatic t_accept();
    apb(1'b1, pic_pkg::ENA_OFS, 32'h7fff);
    ev <= 11'h011;
    @(posedge pclk);
    ev <= 11'h000;
    repeat (8) @(posedge pclk);
    chk("masked_offer", 32'h0, 32'(irq_offer));
    apb(1'b1, pic_pkg::FLAG_OFS, 32'h0);
    take(5'h04);
    apb(1'b0, pic_pkg::FLAG_OFS, 32'h0);
    chk("flag_set", 32'h1, rd);
    apb(1'b0, pic_pkg::REQ_OFS, 32'h0);
    chk("req_cleared", 32'h20, rd);
    apb(1'b0, pic_pkg::STAT_OFS, 32'h0);
    chk("last_prio", 32'h4, rd);
    trap <= 1'b1;
    @(posedge pclk);
    trap <= 1'b0;
    take(5'h11);
    ack_delay <= 4'h6;
    apb(1'b1, pic_pkg::FLAG_OFS, 32'h0);
    take(5'h07);
  endtask : t_accept

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, trap} = 5'h00;
    {paddr, pwdata, ev, ack_delay} = '0;
    pins = 8'h80;  // Trigger pin idles high
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    chk("reset_state", 32'h3fffc, 32'({irq_prio[1:0], vec_fetch, vec_addr}));
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("reset_hi", 32'h1fffd, 32'({vec_fetch, vec_addr}));
    t_regs();
    t_pins();
    t_events();
    t_accept();
    summarize();
  end
endmodule : prioritized_interrupt_controller_bench
